// >>> rtl/ccp_defs.svh
// constants for the capture/compare/pwm block
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH
`define CCP_OC_OFF 3'h0
`define CCP_OC_HIGH 3'h1
`define CCP_OC_LOW 3'h2
`define CCP_OC_TOG 3'h3
`define CCP_OC_DUAL 3'h4
`define CCP_OC_DUALC 3'h5
`define CCP_OC_PWM 3'h6
`define CCP_OC_PWMF 3'h7
`define CCP_IC_OFF 3'h0
`define CCP_IC_BOTH 3'h1
`define CCP_IC_FALL 3'h2
`define CCP_IC_RISE 3'h3
`define CCP_IC_R4 3'h4
`define CCP_IC_R16 3'h5
`define CCP_FIFO_DEPTH 3'h4
`define CCP_DIV4_LAST 4'h3
`define CCP_DIV16_LAST 4'hF
`endif

// >>> rtl/ccp_pkg.sv
// types for the capture/compare/pwm block
package ccp_pkg;
   typedef struct packed {
      logic [2:0] compare_mode_field;
      logic compare_timebase_select;
      logic stop_in_idle;
   } ccp_oc_cfg_t;
   typedef struct packed {
      logic [2:0] capture_mode_field;
      logic capture_timebase_select;
      logic [1:0] events_per_irq;
      logic stop_in_idle;
   } ccp_ic_cfg_t;
endpackage

// >>> rtl/ccp_unit.sv
// two timers, one capture unit and one compare/pwm unit
`include "ccp_defs.svh"
module ccp_unit
   import ccp_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cpu_idle,
   input wire logic [W-1:0] timer_period_reg_2,
   input wire logic [W-1:0] timer_period_reg_3,
   input wire logic tmr_read,
   input wire logic tmr_sel,
   input wire logic [1:0] tmr_read_be,
   output logic [W-1:0] tmr_read_data,
   output logic [1:0] timer_flag,
   input wire ccp_ic_cfg_t ic_cfg,
   input wire logic capture_input_pin,
   input wire logic cap_pop,
   output logic [W-1:0] cap_data,
   output logic cap_buf_empty,
   output logic cap_overflow,
   output logic cap_irq,
   output logic capture_pin_owned,
   input wire ccp_oc_cfg_t oc_cfg,
   input wire logic oc_cfg_wr,
   input wire logic [W-1:0] primary_compare_reg_wr,
   input wire logic primary_wr,
   input wire logic [W-1:0] secondary_compare_reg,
   input wire logic fault_input_a,
   input wire logic fault_input_b,
   input wire logic flag_clr,
   output logic compare_output_pin,
   output logic compare_output_pin_oe_n,
   output logic compare_interrupt_flag,
   output logic pwm_fault_status,
   output logic special_event_trig
);
   // ---------------------------------------------------------------
   // time base timers
   // ---------------------------------------------------------------
   logic [W-1:0] tmr_q [2];
   logic [1:0] tmr_match;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_tmr
         logic [W-1:0] per;
         assign per = (g == 0) ? timer_period_reg_2 : timer_period_reg_3;
         assign tmr_match[g] = (tmr_q[g] == per);
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               tmr_q[g] <= '0;
               timer_flag[g] <= 1'b0;
            end else begin
               tmr_q[g] <= tmr_match[g] ? '0 : tmr_q[g] + 1'b1;
               timer_flag[g] <= tmr_match[g];
            end
         end
      end
   endgenerate

   // full-word only; partial lanes read zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tmr_read_data <= '0;
      end else if (tmr_read) begin
         tmr_read_data <= (tmr_read_be == 2'h3) ? tmr_q[tmr_sel] : '0;
      end
   end

   // ---------------------------------------------------------------
   // capture
   // ---------------------------------------------------------------
   logic ic_s1_q, ic_s2_q, ic_s3_q;
   logic ic_run, rise, fall, cap_ev;
   logic [3:0] pre_q;
   logic [W-1:0] fifo_q [4];
   logic [2:0] cnt_q;
   logic [1:0] rd_q, wr_q, evc_q;
   logic [W-1:0] cap_tb;
   // idle stop and mode off both block capture events; mode off also clears the prescaler and event count
   assign ic_run = (ic_cfg.capture_mode_field != `CCP_IC_OFF)
                   && !(ic_cfg.stop_in_idle && cpu_idle);
   assign capture_pin_owned = (ic_cfg.capture_mode_field != `CCP_IC_OFF);
   assign rise = ic_s2_q && !ic_s3_q;
   assign fall = !ic_s2_q && ic_s3_q;
   assign cap_tb = tmr_q[ic_cfg.capture_timebase_select];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ic_s1_q <= 1'b0;
         ic_s2_q <= 1'b0;
         ic_s3_q <= 1'b0;
      end else begin
         ic_s1_q <= capture_input_pin;
         ic_s2_q <= ic_s1_q;
         ic_s3_q <= ic_s2_q;
      end
   end
   always_comb begin
      cap_ev = 1'b0;
      if (ic_run) begin
         case (ic_cfg.capture_mode_field)
            `CCP_IC_BOTH: cap_ev = rise || fall;
            `CCP_IC_FALL: cap_ev = fall;
            `CCP_IC_RISE: cap_ev = rise;
            `CCP_IC_R4: cap_ev = rise && pre_q == `CCP_DIV4_LAST;
            `CCP_IC_R16: cap_ev = rise && pre_q == `CCP_DIV16_LAST;
            default: cap_ev = 1'b0;
         endcase
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
      end else if (!capture_pin_owned) begin
         pre_q <= '0;
      end else if (ic_run && rise) begin
         if ((ic_cfg.capture_mode_field == `CCP_IC_R4 && pre_q == `CCP_DIV4_LAST)
             || pre_q == `CCP_DIV16_LAST)
            pre_q <= '0;
         else
            pre_q <= pre_q + 4'h1;
      end
   end
   // timer value sampled two cycles after pin edge through synchroniser
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_q <= '0;
         wr_q <= '0;
         cnt_q <= '0;
         cap_overflow <= 1'b0;
         for (int i = 0; i < 4; i++) fifo_q[i] <= '0;
      end else begin
         if (cap_ev && cnt_q != `CCP_FIFO_DEPTH) begin
            fifo_q[wr_q] <= cap_tb;
            wr_q <= wr_q + 2'h1;
         end
         if (cap_pop && cnt_q != 3'h0) rd_q <= rd_q + 2'h1;
         cnt_q <= cnt_q + {2'h0, cap_ev && cnt_q != `CCP_FIFO_DEPTH}
                  - {2'h0, cap_pop && cnt_q != 3'h0};
         // full buffer keeps old values; overflow clears once drained
         if (cap_ev && cnt_q == `CCP_FIFO_DEPTH)
            cap_overflow <= 1'b1;
         else if (cnt_q == 3'h0)
            cap_overflow <= 1'b0;
      end
   end
   assign cap_data = fifo_q[rd_q];
   assign cap_buf_empty = (cnt_q == 3'h0);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         evc_q <= '0;
         cap_irq <= 1'b0;
      end else begin
         cap_irq <= 1'b0;
         if (!capture_pin_owned) begin
            evc_q <= '0;
         end else if (cap_ev) begin
            if (evc_q == ic_cfg.events_per_irq) begin
               evc_q <= '0;
               cap_irq <= 1'b1;
            end else begin
               evc_q <= evc_q + 2'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // compare / pwm
   // ---------------------------------------------------------------
   logic fa_s1_q, fa_s2_q, fb_s1_q, fb_s2_q;
   logic [W-1:0] pri_q, oc_tb;
   logic [2:0] m;
   logic oc_run, hit_pri, hit_sec, per_end, pwm, fault_now, match_ev;
   assign m = oc_cfg.compare_mode_field;
   assign oc_run = (m != `CCP_OC_OFF) && !(oc_cfg.stop_in_idle && cpu_idle);
   assign oc_tb = tmr_q[oc_cfg.compare_timebase_select];
   assign per_end = tmr_match[oc_cfg.compare_timebase_select];
   assign pwm = (m == `CCP_OC_PWM) || (m == `CCP_OC_PWMF);
   assign hit_pri = oc_run && (oc_tb == pri_q);
   assign hit_sec = oc_run && (oc_tb == secondary_compare_reg);
   // only the two dedicated pins, synchronised, reach the fault logic
   assign fault_now = (m == `CCP_OC_PWMF) && !(fa_s2_q && fb_s2_q);
   assign match_ev = hit_pri || (hit_sec && !pwm && m >= `CCP_OC_DUAL);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fa_s1_q <= 1'b1;
         fa_s2_q <= 1'b1;
         fb_s1_q <= 1'b1;
         fb_s2_q <= 1'b1;
      end else begin
         fa_s1_q <= fault_input_a;
         fa_s2_q <= fa_s1_q;
         fb_s1_q <= fault_input_b;
         fb_s2_q <= fb_s1_q;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pri_q <= '0;
      end else if (primary_wr) begin
         pri_q <= primary_compare_reg_wr;
      end else if (pwm && per_end) begin
         pri_q <= secondary_compare_reg;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pwm_fault_status <= 1'b0;
      end else if (fault_now) begin
         pwm_fault_status <= 1'b1;
      end else if (oc_cfg_wr && pwm && fa_s2_q && fb_s2_q) begin
         pwm_fault_status <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         compare_output_pin <= 1'b0;
      end else if (oc_cfg_wr) begin
         // initial level chosen by mode write
         compare_output_pin <= (m == `CCP_OC_LOW);
      end else if (oc_run && !pwm_fault_status) begin
         case (m)
            `CCP_OC_HIGH: if (hit_pri) compare_output_pin <= 1'b1;
            `CCP_OC_LOW: if (hit_pri) compare_output_pin <= 1'b0;
            `CCP_OC_TOG: if (hit_pri) compare_output_pin <= !compare_output_pin;
            `CCP_OC_DUAL, `CCP_OC_DUALC: begin
               if (hit_pri) compare_output_pin <= 1'b1;
               else if (hit_sec) compare_output_pin <= 1'b0;
            end
            `CCP_OC_PWM, `CCP_OC_PWMF: begin
               if (per_end) compare_output_pin <= (secondary_compare_reg != '0);
               else if (hit_pri) compare_output_pin <= 1'b0;
            end
            default: compare_output_pin <= compare_output_pin;
         endcase
      end
   end
   // fault has no selectable level: the pin is released
   assign compare_output_pin_oe_n = (m == `CCP_OC_OFF) || pwm_fault_status;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         compare_interrupt_flag <= 1'b0;
         special_event_trig <= 1'b0;
      end else begin
         special_event_trig <= match_ev && !pwm;
         if (match_ev || (pwm && per_end && oc_run) || fault_now)
            compare_interrupt_flag <= 1'b1;
         else if (flag_clr)
            compare_interrupt_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_fault_tristate: assert property (@(posedge ref_clk) disable iff (rst)
      fault_now |=> compare_output_pin_oe_n) else $error("fault did not release pin");
   a_fault_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
      fault_now |=> pwm_fault_status && compare_interrupt_flag)
      else $error("fault flags missing");
   a_no_overwrite: assert property (@(posedge ref_clk) disable iff (rst)
      (cap_ev && cnt_q == `CCP_FIFO_DEPTH) |=> cap_overflow && $stable(wr_q))
      else $error("full buffer overwritten");
   a_cap_first_store: assert property (@(posedge ref_clk) disable iff (rst)
      (cap_ev && cap_buf_empty) |=> !cap_buf_empty && cap_data == $past(cap_tb))
      else $error("first capture not at head");
   a_match_flag: assert property (@(posedge ref_clk) disable iff (rst)
      match_ev |=> compare_interrupt_flag) else $error("match missed flag");
   a_pwm_reload: assert property (@(posedge ref_clk) disable iff (rst)
      (pwm && per_end && !primary_wr) |=> pri_q == $past(secondary_compare_reg))
      else $error("duty not reloaded");
   a_timer_wrap: assert property (@(posedge ref_clk) disable iff (rst)
      tmr_match[0] |=> timer_flag[0] && tmr_q[0] == '0) else $error("timer wrap wrong");
   a_byte_read_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (tmr_read && tmr_read_be != 2'h3) |=> tmr_read_data == '0)
      else $error("byte read not zero");
   a_toggle_next: assert property (@(posedge ref_clk) disable iff (rst)
      (m == `CCP_OC_TOG && hit_pri && !oc_cfg_wr && !pwm_fault_status)
      |=> compare_output_pin != $past(compare_output_pin)) else $error("toggle late");
   a_dual_fall: assert property (@(posedge ref_clk) disable iff (rst)
      ((m == `CCP_OC_DUAL || m == `CCP_OC_DUALC) && hit_sec && !hit_pri && !oc_cfg_wr
      && !pwm_fault_status) |=> !compare_output_pin) else $error("dual fall missed");
   a_pwm_period_set: assert property (@(posedge ref_clk) disable iff (rst)
      (pwm && per_end && oc_run && !oc_cfg_wr && !pwm_fault_status
      && secondary_compare_reg != '0) |=> compare_output_pin)
      else $error("pwm period start missed");
   a_fault_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (pwm_fault_status && !oc_cfg_wr) |=> pwm_fault_status)
      else $error("fault cleared without mode write");
   // idle halt must freeze the buffer even with edges arriving
   a_cap_idle_halt: assert property (@(posedge ref_clk) disable iff (rst)
      (ic_cfg.stop_in_idle && cpu_idle) |=> !cap_irq && $stable(wr_q))
      else $error("capture ran in idle");
   c_capture_ovf: cover property (@(posedge ref_clk) cap_ev && cnt_q == `CCP_FIFO_DEPTH);
   c_pwm_fault: cover property (@(posedge ref_clk) fault_now);
   c_cap_irq: cover property (@(posedge ref_clk) cap_irq);
   c_dual_hit: cover property (@(posedge ref_clk) m == `CCP_OC_DUAL && hit_sec);
   c_pwm_restart: cover property (@(posedge ref_clk) $fell(pwm_fault_status));
endmodule

// >>> verif/ccp_pin_model.sv
// pin-side partner: capture source, fault switches, pwm load
module ccp_pin_model (
   input wire logic cap_lvl,
   input wire logic flt_a_n,
   input wire logic flt_b_n,
   input wire logic compare_output_pin,
   input wire logic compare_output_pin_oe_n,
   output logic capture_input_pin,
   output logic fault_input_a,
   output logic fault_input_b,
   output logic load_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // pins
   // ----------------------------------------
   assign capture_input_pin = cap_lvl;
   // fault lines idle high on pull-ups; only these two exist
   assign fault_input_a = flt_a_n;
   assign fault_input_b = flt_b_n;
   // load pulls down, so a released pin reads low
   assign load_level = compare_output_pin_oe_n ? 1'b0 : compare_output_pin;
endmodule

// >>> verif/testbench.sv
// self-checking bench for the capture/compare/pwm unit
`include "ccp_defs.svh"
module testbench;
   import ccp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic ref_clk, rst, cpu_idle, tmr_read, tmr_sel, oc_cfg_wr, primary_wr, flag_clr;
   logic cap_pop = 1'b0;
   logic [15:0] p2, p3, pri, sec, tmr_read_data, cap_data, h;
   logic [1:0] tmr_read_be, timer_flag;
   ccp_ic_cfg_t ic_cfg;
   ccp_oc_cfg_t oc_cfg;
   logic cap_buf_empty, cap_overflow, cap_irq, capture_pin_owned, compare_output_pin;
   logic compare_output_pin_oe_n, compare_interrupt_flag, pwm_fault_status, special_event_trig;
   logic cap_lvl, flt_a_n, flt_b_n, capture_input_pin, fault_input_a, fault_input_b, load_level;
   logic pop_en, lvl_q;
   logic [15:0] exp_q[$];
   logic [15:0] ecnt[5] = '{16'h0020, 16'h0010, 16'h0010, 16'h0004, 16'h0001};
   logic [31:0] seed;
   int fail_count = 0, tests_run = 0, cyc = 0, irq_n = 0, sev_n = 0, last_f = 0, gap = 0;
   int rise_t = 0, per = 0, hi = 0, b, h1;
   ccp_unit uut (.ref_clk(ref_clk), .rst(rst), .cpu_idle(cpu_idle),
      .timer_period_reg_2(p2), .timer_period_reg_3(p3), .tmr_read(tmr_read),
      .tmr_sel(tmr_sel), .tmr_read_be(tmr_read_be), .tmr_read_data(tmr_read_data),
      .timer_flag(timer_flag), .ic_cfg(ic_cfg), .capture_input_pin(capture_input_pin),
      .cap_pop(cap_pop), .cap_data(cap_data), .cap_buf_empty(cap_buf_empty),
      .cap_overflow(cap_overflow), .cap_irq(cap_irq), .capture_pin_owned(capture_pin_owned),
      .oc_cfg(oc_cfg), .oc_cfg_wr(oc_cfg_wr), .primary_compare_reg_wr(pri),
      .primary_wr(primary_wr), .secondary_compare_reg(sec), .fault_input_a(fault_input_a),
      .fault_input_b(fault_input_b), .flag_clr(flag_clr),
      .compare_output_pin(compare_output_pin), .compare_output_pin_oe_n(compare_output_pin_oe_n),
      .compare_interrupt_flag(compare_interrupt_flag), .pwm_fault_status(pwm_fault_status),
      .special_event_trig(special_event_trig));
   ccp_pin_model pins (.cap_lvl(cap_lvl), .flt_a_n(flt_a_n), .flt_b_n(flt_b_n),
      .compare_output_pin(compare_output_pin), .compare_output_pin_oe_n(compare_output_pin_oe_n),
      .capture_input_pin(capture_input_pin), .fault_input_a(fault_input_a),
      .fault_input_b(fault_input_b), .load_level(load_level));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(1);
   endtask
   task automatic ocm(input logic [2:0] m);
      oc_cfg = '{m, 1'b0, 1'b0};
      pulse(oc_cfg_wr);
   endtask
   task automatic rises(input int n);
      repeat (n) begin
         cap_lvl = 1'b1;
         tick(10);
         cap_lvl = 1'b0;
         tick(10);
      end
   endtask
   task automatic capmode(input logic [2:0] m, input logic [1:0] e, input logic idle);
      ic_cfg = '{m, 1'b1, e, idle};
      tick(3);
      b = irq_n;
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // watchers: event counts, pin timing, read answers
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      lvl_q <= load_level;
      if (cap_irq === 1'b1) irq_n <= irq_n + 1;
      if (special_event_trig === 1'b1) sev_n <= sev_n + 1;
      if (timer_flag[0] === 1'b1) begin
         gap <= cyc - last_f;
         last_f <= cyc;
      end
      if (load_level === 1'b1 && lvl_q === 1'b0) begin
         per <= cyc - rise_t;
         rise_t <= cyc;
      end
      if (load_level === 1'b0 && lvl_q === 1'b1) hi <= cyc - rise_t;
      cap_pop <= #1 pop_en && cap_buf_empty === 1'b0;
   end
   initial begin
      logic pend, taken;
      pend = 1'b0;
      forever begin
         @(posedge ref_clk);
         taken = tmr_read;
         #2;
         if (pend && exp_q.size() > 0) chk(tmr_read_data, exp_q.pop_front());
         pend = taken;
      end
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      summarize();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1; cpu_idle = 1'b0; p2 = 16'h0063; p3 = 16'hFFFF; tmr_read = 1'b0;
      tmr_sel = 1'b0; tmr_read_be = 2'h0; ic_cfg = '{3'h0, 1'b0, 2'h0, 1'b0};
      oc_cfg = '{3'h0, 1'b0, 1'b0}; oc_cfg_wr = 1'b0; pri = 16'h0000; primary_wr = 1'b0;
      sec = 16'h0000; flag_clr = 1'b0; cap_lvl = 1'b0; flt_a_n = 1'b1; flt_b_n = 1'b1;
      pop_en = 1'b0; seed = 32'h02B2;
      tick(2);
      rst = 1'b0;
      chk(compare_output_pin_oe_n, 16'h0001);
      chk(cap_buf_empty, 16'h0001);
      repeat (12) begin
         seed = xs(seed);
         tmr_sel = seed[4];
         tmr_read_be = seed[6:5];
         // timers count from the first edge after reset; only a full word reads back
         exp_q.push_back(tmr_read_be != 2'h3 ? 16'h0000
                         : tmr_sel ? 16'(cyc - 2) : 16'((cyc - 2) % (int'(p2) + 1)));
         pulse(tmr_read);
      end
      tick(3);
      chk(16'(exp_q.size()), 16'h0000);
      $display("done: byte reads");
      pop_en = 1'b1;
      foreach (ecnt[i]) begin
         capmode(3'(i + 1), 2'h0, 1'b0);
         rises(16);
         tick(6);
         chk(16'(irq_n - b), ecnt[i]);
         chk(capture_pin_owned, 16'h0001);
         capmode(`CCP_IC_OFF, 2'h0, 1'b0);
      end
      chk(capture_pin_owned, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         capmode(`CCP_IC_RISE, 2'(k), 1'b0);
         rises(12);
         tick(6);
         chk(16'(irq_n - b), 16'(12 / (k + 1)));
         capmode(`CCP_IC_OFF, 2'h0, 1'b0);
      end
      cpu_idle = 1'b1;
      capmode(`CCP_IC_RISE, 2'h0, 1'b1);
      rises(4);
      tick(6);
      chk(16'(irq_n - b), 16'h0000);
      cpu_idle = 1'b0;
      $display("done: capture modes");
      pop_en = 1'b0;
      capmode(`CCP_IC_RISE, 2'h0, 1'b0);
      rises(5);
      tick(6);
      chk(cap_overflow, 16'h0001);
      repeat (4) begin
         h = cap_data;
         pulse(pop_en);
         tick(1);
         if (cap_buf_empty === 1'b0) chk(cap_data - h, 16'h0014);
      end
      chk(cap_buf_empty, 16'h0001);
      chk(cap_overflow, 16'h0000);
      capmode(`CCP_IC_OFF, 2'h0, 1'b0);
      chk(16'(gap), 16'h0064);
      $display("done: capture buffer");
      pri = 16'h0032;
      pulse(primary_wr);
      b = sev_n;
      ocm(`CCP_OC_HIGH);
      tick(250);
      chk(load_level, 16'h0001);
      chk(compare_interrupt_flag, 16'h0001);
      chk(16'(sev_n > b), 16'h0001);
      pulse(flag_clr);
      ocm(`CCP_OC_LOW);
      tick(250);
      chk(load_level, 16'h0000);
      chk(compare_output_pin_oe_n, 16'h0000);
      chk(compare_interrupt_flag, 16'h0001);
      ocm(`CCP_OC_TOG);
      tick(450);
      chk(16'(per), 16'h00C8);
      pri = 16'h0014;
      pulse(primary_wr);
      sec = 16'h0046;
      for (int m = 4; m < 6; m++) begin
         ocm(`CCP_OC_OFF);
         ocm(3'(m));
         tick(250);
         chk(16'(hi), 16'h0032);
      end
      chk(16'(per), 16'h0064);
      $display("done: compare modes");
      sec = 16'h001E;
      ocm(`CCP_OC_PWM);
      tick(300);
      chk(16'(per), 16'h0064);
      h1 = hi;
      sec = 16'h003C;
      tick(300);
      chk(16'(hi - h1), 16'h001E);
      pulse(flag_clr);
      tick(150);
      chk(compare_interrupt_flag, 16'h0001);
      for (int f = 0; f < 2; f++) begin
         ocm(`CCP_OC_PWMF);
         tick(250);
         chk(compare_output_pin_oe_n, 16'h0000);
         if (f == 0) flt_a_n = 1'b0;
         else flt_b_n = 1'b0;
         tick(3);
         flt_a_n = 1'b1;
         flt_b_n = 1'b1;
         tick(5);
         chk(compare_output_pin_oe_n, 16'h0001);
         chk(pwm_fault_status, 16'h0001);
         tick(300);
         chk(load_level, 16'h0000);
      end
      ocm(`CCP_OC_PWMF);
      tick(250);
      chk(16'(per), 16'h0064);
      $display("done: pwm and fault");
      summarize();
   end
endmodule
